// *** rtl/msd_map.vh ***
// Constants for the memory select and page decode block
// What this block does
// - SRAM enabled only while the SRAM select is high; up to three terms.
// - Decoder outputs primary sector, secondary sector and SRAM selects from equations.
// - Secondary sector wins over an overlapping primary sector.
// - SRAM, register or peripheral I/O wins over any overlapping flash sector.
// - Three fixed priority levels; level 1 wins; overlapping same-level parts all assert together.
// - Split spaces: fetch strobe decodes program, read strobe decodes data.
// - Space map loads initial value at reset; host rewrites take effect at once.
// - Space map 0Ch: primary answers fetches; others answer data reads.
// - Space map bits 2 and 4 set: primary answers both strobes.
// - 8-bit page register on data 7:0 at config offset E0h, read and write.
// - Page bits feed decoder terms and the general logic array.
// - Read-only memory ID registers report memory configuration.
// - Fast-response bit clear: arrays standby after inputs idle about 70 ns.
// - Three power mode two bits block host strobes from the arrays.
// - Array input bus carries 82 signals in documented groups.
// - Split-space host mode uses address bits 19 to 4 for decoder.
`ifndef MSD_MAP_VH
`define MSD_MAP_VH
`define MSD_OFS_PAGE      8'hE0
`define MSD_OFS_SPACE_MAP 8'hE2
`define MSD_OFS_ID0       8'hF0
`define MSD_OFS_ID1       8'hF1
`define MSD_OFS_PMR0      8'hB0
`define MSD_OFS_PMR2      8'hB4
`define MSD_SPACE_MAP_RST 8'h0C
`define MSD_BIT_FAST      3
`define MSD_BIT_PRI_FETCH 2
`define MSD_BIT_SEC_FETCH 0
`define MSD_BIT_RAM_FETCH 1
`define MSD_BIT_PRI_READ  4
`define MSD_BIT_SEC_READ  3
`define MSD_IDLE_NS       70
`define MSD_CLK_NS        10
`define MSD_IDLE_CYC      ((`MSD_IDLE_NS + `MSD_CLK_NS - 1) / `MSD_CLK_NS)
`define MSD_BUS_W         82
`endif

// *** rtl/msd_term.v ***
// Product-term select: OR of up to three masked address terms
`timescale 1ns/100ps
module msd_term #(
	parameter W = 24,
	parameter N = 3
) (
	// Decoder inputs
	input  wire [W-1:0]   in_i,
	// Term configuration
	input  wire [N*W-1:0] care_i,
	input  wire [N*W-1:0] val_i,
	input  wire [N-1:0]   used_i,
	// Select
	output wire           hit_o
);
	wire [N-1:0] t;
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : gt
			assign t[g] = used_i[g] &
				(((in_i ^ val_i[g*W +: W]) & care_i[g*W +: W]) == {W{1'b0}});
		end
	endgenerate
	assign hit_o = |t;
endmodule

// *** rtl/msd_idle.v ***
// Input activity watch for array standby
`timescale 1ns/100ps
module msd_idle #(
	parameter W   = 82,
	parameter CYC = 7
) (
	// Clock and reset
	input  wire         clk_i,
	input  wire         nrst_i,
	// Watched bus
	input  wire [W-1:0] bus_i,
	input  wire         fast_i,
	// Standby state
	output reg          standby_o
);
	reg [W-1:0] last;
	reg [7:0]   cnt;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			last      <= {W{1'b0}};
			cnt       <= 8'h00;
			standby_o <= 1'b0;
		end else begin
			last <= bus_i;
			if (fast_i || bus_i != last) begin
				cnt       <= 8'h00;
				standby_o <= 1'b0;
			end else if (cnt < CYC[7:0]) begin
				cnt <= cnt + 8'h01;
			end else begin
				standby_o <= 1'b1;
			end
		end
	end
endmodule

// *** rtl/msd_decode.v ***
// Memory select, space map, page register and array input bus
`timescale 1ns/100ps
`include "msd_map.vh"
module msd_decode #(
	parameter W   = 24,
	// Memory ID values arbitrary
	parameter [7:0] ID0 = 8'h00,
	parameter [7:0] ID1 = 8'h00,
	parameter [7:0] MAP_INIT = `MSD_SPACE_MAP_RST
) (
	// Clock and reset
	input  wire          clk_i,
	input  wire          nrst_i,
	// Host bus
	input  wire [19:0]   addr_i,
	input  wire [7:0]    wdata_i,
	input  wire          wr_n_i,
	input  wire          rd_n_i,
	input  wire          fetch_n_i,
	input  wire          split_mode_i,
	// Config block select and I/O selects
	input  wire          cfg_sel_i,
	input  wire          io_sel_i,
	input  wire          per_sel_i,
	// Select equations
	input  wire [8*3*W-1:0] pri_care_i,
	input  wire [8*3*W-1:0] pri_val_i,
	input  wire [8*3-1:0]   pri_used_i,
	input  wire [4*3*W-1:0] sec_care_i,
	input  wire [4*3*W-1:0] sec_val_i,
	input  wire [4*3-1:0]   sec_used_i,
	input  wire [3*W-1:0]   ram_care_i,
	input  wire [3*W-1:0]   ram_val_i,
	input  wire [2:0]       ram_used_i,
	// Other array inputs
	input  wire          reset_i,
	input  wire          power_down_input_i,
	input  wire [23:0]   port_cells_i,
	input  wire [3:0]    port_d_i,
	input  wire [7:0]    port_f_i,
	input  wire [7:0]    cell_group_a_feedback_i,
	input  wire [7:0]    cell_group_b_feedback_i,
	input  wire          flash_ready_i,
	// Outputs
	output reg  [7:0]    rdata_o,
	output reg           rdata_oe_o,
	output reg  [7:0]    primary_sector_selects_o,
	output reg  [3:0]    secondary_sector_selects_o,
	output reg           ram_select_o,
	output reg           io_select_o,
	output reg  [7:0]    page_bits_o,
	output reg  [`MSD_BUS_W-1:0] array_bus_o,
	output reg           standby_o
);
	reg  [7:0] page_extension_register;
	reg  [7:0] space_map_register;
	reg  [7:0] power_mode_reg_zero;
	reg  [7:0] power_mode_reg_two;
	reg        wr_d;
	wire [15:0] dec_addr;
	wire [W-1:0] dec_in;
	wire [7:0]  pri_hit;
	wire [3:0]  sec_hit;
	wire        ram_hit;
	wire        fetch;
	wire        rd;
	wire        io_any;
	wire        ram_act;
	wire [3:0]  sec_act;
	wire        pri_ok;
	wire        sec_ok;
	wire        ram_ok;
	wire        wr_end;
	wire [2:0]  strobes;
	wire [`MSD_BUS_W-1:0] next_bus;
	wire        idle_sb;
	reg  [7:0]  next_rdata;
	reg         next_oe;

	assign dec_addr = split_mode_i ? addr_i[19:4] : addr_i[15:0];
	assign dec_in   = {page_extension_register, dec_addr};
	assign fetch    = ~fetch_n_i;
	assign rd       = ~rd_n_i;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gp
			msd_term #(.W(W), .N(3)) u_pri (
				.in_i   (dec_in),
				.care_i (pri_care_i[g*3*W +: 3*W]),
				.val_i  (pri_val_i[g*3*W +: 3*W]),
				.used_i (pri_used_i[g*3 +: 3]),
				.hit_o  (pri_hit[g])
			);
		end
		for (g = 0; g < 4; g = g + 1) begin : gs
			msd_term #(.W(W), .N(3)) u_sec (
				.in_i   (dec_in),
				.care_i (sec_care_i[g*3*W +: 3*W]),
				.val_i  (sec_val_i[g*3*W +: 3*W]),
				.used_i (sec_used_i[g*3 +: 3]),
				.hit_o  (sec_hit[g])
			);
		end
	endgenerate
	msd_term #(.W(W), .N(3)) u_ram (
		.in_i   (dec_in),
		.care_i (ram_care_i),
		.val_i  (ram_val_i),
		.used_i (ram_used_i),
		.hit_o  (ram_hit)
	);

	// Space gating per strobe
	assign pri_ok = (fetch & space_map_register[`MSD_BIT_PRI_FETCH])
		| (rd & (~split_mode_i | space_map_register[`MSD_BIT_PRI_READ]));
	assign sec_ok = (fetch & space_map_register[`MSD_BIT_SEC_FETCH])
		| (rd & (~split_mode_i | space_map_register[`MSD_BIT_SEC_READ]));
	assign ram_ok = (fetch & space_map_register[`MSD_BIT_RAM_FETCH]) | rd;
	// Only a select live in this space may win priority
	assign ram_act = ram_hit & ram_ok;
	assign sec_act = sec_hit & {4{sec_ok}};
	assign io_any  = ram_act | cfg_sel_i | io_sel_i | per_sel_i;

	// Priority: level 1 I/O and SRAM, level 2 secondary, level 3 primary
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			primary_sector_selects_o   <= 8'h00;
			secondary_sector_selects_o <= 4'h0;
			ram_select_o               <= 1'b0;
			io_select_o                <= 1'b0;
		end else begin
			ram_select_o <= ram_act;
			io_select_o  <= (cfg_sel_i | io_sel_i | per_sel_i) & (rd | ~wr_n_i);
			secondary_sector_selects_o <= io_any ? 4'h0 : sec_act;
			primary_sector_selects_o <= (io_any | (|sec_act)) ? 8'h00
				: (pri_hit & {8{pri_ok}});
		end
	end

	// Register writes on trailing write edge
	assign wr_end = wr_d & wr_n_i;
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wr_d                    <= 1'b0;
			page_extension_register <= 8'h00;
			space_map_register      <= MAP_INIT;
			power_mode_reg_zero     <= 8'h00;
			power_mode_reg_two      <= 8'h00;
		end else begin
			wr_d <= ~wr_n_i & cfg_sel_i;
			if (wr_end) begin
				if (addr_i[7:0] == `MSD_OFS_PAGE) begin
					page_extension_register <= wdata_i;
				end else if (addr_i[7:0] == `MSD_OFS_SPACE_MAP) begin
					space_map_register <= wdata_i;
				end else if (addr_i[7:0] == `MSD_OFS_PMR0) begin
					power_mode_reg_zero <= wdata_i;
				end else if (addr_i[7:0] == `MSD_OFS_PMR2) begin
					power_mode_reg_two <= wdata_i;
				end
			end
		end
	end

	// Register reads
	always @* begin
		next_rdata = 8'h00;
		next_oe    = cfg_sel_i & rd;
		if (addr_i[7:0] == `MSD_OFS_PAGE) begin
			next_rdata = page_extension_register;
		end else if (addr_i[7:0] == `MSD_OFS_SPACE_MAP) begin
			next_rdata = space_map_register;
		end else if (addr_i[7:0] == `MSD_OFS_ID0) begin
			next_rdata = ID0;
		end else if (addr_i[7:0] == `MSD_OFS_ID1) begin
			next_rdata = ID1;
		end else if (addr_i[7:0] == `MSD_OFS_PMR0) begin
			next_rdata = power_mode_reg_zero;
		end else if (addr_i[7:0] == `MSD_OFS_PMR2) begin
			next_rdata = power_mode_reg_two;
		end else begin
			next_oe = 1'b0;
		end
	end

	// Strobe blocking and array input bus
	assign strobes = {fetch_n_i, rd_n_i, wr_n_i} & ~power_mode_reg_two[2:0];
	assign next_bus = {dec_addr, strobes, reset_i, power_down_input_i, port_cells_i,
		port_d_i, port_f_i, page_extension_register, cell_group_a_feedback_i,
		cell_group_b_feedback_i, flash_ready_i};

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o     <= 8'h00;
			rdata_oe_o  <= 1'b0;
			page_bits_o <= 8'h00;
			array_bus_o <= {`MSD_BUS_W{1'b0}};
			standby_o   <= 1'b0;
		end else begin
			rdata_o     <= next_rdata;
			rdata_oe_o  <= next_oe;
			page_bits_o <= page_extension_register;
			array_bus_o <= next_bus;
			standby_o   <= idle_sb;
		end
	end

	msd_idle #(.W(`MSD_BUS_W), .CYC(`MSD_IDLE_CYC)) u_idle (
		.clk_i     (clk_i),
		.nrst_i    (nrst_i),
		.bus_i     (next_bus),
		.fast_i    (power_mode_reg_zero[`MSD_BIT_FAST]),
		.standby_o (idle_sb)
	);
endmodule

// *** tb/msd_checker.sv ***
// Port assertions for the decode block
`timescale 1ns/100ps
module msd_chk (
	// Clock and reset
	input wire logic	clk_i,
	input wire logic	nrst_i,
	// Host bus
	input wire logic [19:0]	addr_i,
	input wire logic [7:0]	wdata_i,
	input wire logic	wr_n_i,
	input wire logic	rd_n_i,
	input wire logic	cfg_sel_i,
	input wire logic	split_mode_i,
	// Outputs
	input wire logic	rdata_oe_o,
	input wire logic [7:0]	primary_sector_selects_o,
	input wire logic [3:0]	secondary_sector_selects_o,
	input wire logic	ram_select_o,
	input wire logic [7:0]	page_bits_o,
	input wire logic [81:0]	array_bus_o,
	input wire logic	standby_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	ram_pri_a: assert property (
		ram_select_o |-> !primary_sector_selects_o && !secondary_sector_selects_o)
		else $error("flash select beside ram select");
	sec_pri_a: assert property (
		|secondary_sector_selects_o |-> !primary_sector_selects_o)
		else $error("primary select beside secondary select");
	page_wr_a: assert property (
		cfg_sel_i && !wr_n_i ##1 cfg_sel_i && wr_n_i && addr_i[7:0] == 8'hE0
		|-> ##2 page_bits_o == $past(wdata_i, 2))
		else $error("page register not loaded");
	bus_page_a: assert property (
		page_bits_o == $past(page_bits_o) && page_bits_o == $past(page_bits_o, 2)
		|-> array_bus_o[24:17] == page_bits_o)
		else $error("page bits missing from array bus");
	bus_addr_a: assert property (
		$past(nrst_i) |-> array_bus_o[81:66] == ($past(split_mode_i)
		? $past(addr_i[19:4]) : $past(addr_i[15:0])))
		else $error("decoder address field wrong");
	cfg_rd_a: assert property (rdata_oe_o |-> $past(cfg_sel_i) && !$past(rd_n_i))
		else $error("read data enabled without config read");
	unmapped_a: assert property (
		cfg_sel_i && !rd_n_i && addr_i[7:0] == 8'h55 |=> !rdata_oe_o)
		else $error("unmapped offset answered");
	wake_a: assert property ($changed(addr_i[15:4]) |-> ##[1:3] !standby_o)
		else $error("standby kept while inputs change");
	cover property (ram_select_o);
	cover property (rdata_oe_o);
	cover property (standby_o);
endmodule

// *** tb/msd_host.sv ***
// Host bus model driving address, data and strobes
`timescale 1ns/100ps
module msd_host (
	// Clock
	input wire logic	clk_i,
	// Host bus
	output logic [19:0]	addr_o,
	output logic [7:0]	wdata_o,
	output logic	wr_n_o,
	output logic	rd_n_o,
	output logic	fetch_n_o,
	output logic	cfg_sel_o
);
	initial begin
		addr_o = 20'h00000;
		wdata_o = 8'h00;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		fetch_n_o = 1'b1;
		cfg_sel_o = 1'b0;
	end
	task cfg_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		cfg_sel_o = 1'b1;
		addr_o = {12'h000, a};
		wdata_o = d;
		wr_n_o = 1'b0;
		@(negedge clk_i);
		wr_n_o = 1'b1;
		@(negedge clk_i);
		cfg_sel_o = 1'b0;
		wdata_o = ~d;
	endtask
	task acc(input logic cfg, input logic fetch, input logic [19:0] a);
		@(negedge clk_i);
		cfg_sel_o = cfg;
		addr_o = a;
		rd_n_o = fetch;
		fetch_n_o = ~fetch;
		@(negedge clk_i);
		rd_n_o = 1'b1;
		fetch_n_o = 1'b1;
		cfg_sel_o = 1'b0;
	endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the decode block
`timescale 1ns/100ps
module tb;
	logic	clk_i, nrst_i, wr_n_i, rd_n_i, fetch_n_i, cfg_sel_i, split_mode_i, io_sel_i;
	logic	per_sel_i, rdata_oe_o, ram_select_o, io_select_o, standby_o, reset_i;
	logic	power_down_input_i, flash_ready_i;
	logic [19:0]	addr_i;
	logic [7:0]	wdata_i, rdata_o, primary_sector_selects_o, page_bits_o, port_f_i;
	logic [7:0]	cell_group_a_feedback_i, cell_group_b_feedback_i;
	logic [3:0]	secondary_sector_selects_o, port_d_i;
	logic [23:0]	port_cells_i, pri_used_i;
	logic [575:0]	pri_care_i, pri_val_i;
	logic [287:0]	sec_care_i, sec_val_i;
	logic [71:0]	ram_care_i, ram_val_i;
	logic [11:0]	sec_used_i;
	logic [2:0]	ram_used_i;
	logic [81:0]	array_bus_o;
	logic [54:0]	oth;
	int	errors, n_checks, cyc;
	assign {reset_i, power_down_input_i, port_cells_i, port_d_i, port_f_i,
		cell_group_a_feedback_i, cell_group_b_feedback_i, flash_ready_i} = oth;
	// Memory ID value arbitrary
	msd_decode #(.ID0(8'h3C)) dut (.*);
	msd_host host (.clk_i, .addr_o(addr_i), .wdata_o(wdata_i), .wr_n_o(wr_n_i),
		.rd_n_o(rd_n_i), .fetch_n_o(fetch_n_i), .cfg_sel_o(cfg_sel_i));
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task finish_test;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task sel(input logic [19:0] a, input logic f, input logic [12:0] exp);
		host.acc(1'b0, f, a);
		chk({primary_sector_selects_o, secondary_sector_selects_o, ram_select_o}, exp);
	endtask
	task t_page;
		chk(page_bits_o, 8'h00);
		host.cfg_wr(8'hE0, 8'h5A);
		@(negedge clk_i);
		chk(page_bits_o, 8'h5A);
		chk(array_bus_o[24:17], 8'h5A);
		host.acc(1'b1, 1'b0, 20'h000E0);
		chk({rdata_oe_o, rdata_o}, 9'h15A);
		host.acc(1'b1, 1'b0, 20'h000F0);
		chk({rdata_oe_o, rdata_o}, 9'h13C);
		host.acc(1'b1, 1'b0, 20'h00055);
		chk(rdata_oe_o, 1'b0);
	endtask
	task t_prio;
		sel(20'h08000, 1'b0, 13'h0001);
		sel(20'h09000, 1'b0, 13'h0002);
		sel(20'h0A000, 1'b0, 13'h0020);
		sel(20'h0C000, 1'b0, 13'h0040);
		sel(20'h0D000, 1'b0, 13'h0000);
		io_sel_i = 1'b1;
		sel(20'h0A000, 1'b0, 13'h0000);
		chk(io_select_o, 1'b1);
		io_sel_i = 1'b0;
	endtask
	task t_split;
		split_mode_i = 1'b1;
		sel(20'hA0000, 1'b1, 13'h0020);
		sel(20'hA0000, 1'b0, 13'h0000);
		sel(20'h90000, 1'b0, 13'h0002);
		sel(20'h90000, 1'b1, 13'h0020);
		host.cfg_wr(8'hE2, 8'h14);
		sel(20'hA0000, 1'b0, 13'h0020);
		split_mode_i = 1'b0;
	endtask
	task t_bus;
		oth = 55'h2A5555AAAA3C96;
		repeat (2) @(negedge clk_i);
		chk(array_bus_o[62:0], {oth[54:17], 8'h5A, oth[16:0]});
	endtask
	task t_reset;
		host.acc(1'b1, 1'b0, 20'h000E2);
		chk({rdata_oe_o, rdata_o}, 9'h114);
		nrst_i = 1'b0;
		@(negedge clk_i);
		nrst_i = 1'b1;
		host.acc(1'b1, 1'b0, 20'h000E2);
		chk({rdata_oe_o, rdata_o}, 9'h10C);
		chk(page_bits_o, 8'h00);
	endtask
	task t_power;
		repeat (12) @(negedge clk_i);
		chk(standby_o, 1'b1);
		host.cfg_wr(8'hB0, 8'h08);
		repeat (12) @(negedge clk_i);
		chk(standby_o, 1'b0);
		host.cfg_wr(8'hB4, 8'h07);
		@(negedge clk_i);
		chk(array_bus_o[65:63], 3'h0);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			errors++;
			finish_test;
		end
	end
	initial begin
		nrst_i = 1'b0;
		split_mode_i = 1'b0;
		io_sel_i = 1'b0;
		per_sel_i = 1'b0;
		oth = '0;
		{pri_care_i, pri_val_i, sec_care_i, sec_val_i, ram_care_i, ram_val_i} = '0;
		pri_care_i[23:0] = 24'h00C000;
		pri_val_i[23:0] = 24'h008000;
		pri_care_i[95:72] = 24'hFFF000;
		pri_val_i[95:72] = 24'h5AC000;
		pri_used_i = 24'h000009;
		sec_care_i[23:0] = 24'h00E000;
		sec_val_i[23:0] = 24'h008000;
		sec_used_i = 12'h001;
		ram_care_i[23:0] = 24'h00F800;
		ram_val_i[23:0] = 24'h008000;
		ram_used_i = 3'h1;
		repeat (4) @(negedge clk_i);
		nrst_i = 1'b1;
		t_page;
		t_prio;
		t_split;
		t_bus;
		t_reset;
		t_power;
		finish_test;
	end
endmodule
bind msd_decode msd_chk chk (.*);
